// ---- rtl/mbapm_pkg.sv ----
// Purpose: shared constants for the bus address capture and port mux
// Assumes: four ports, A..D, D only three pins wide
// Notes: register offsets are low-byte offsets inside the io page
package mbapm_pkg;

  typedef enum logic [4:0] {
    MBAPM_MUX8 = 5'h01,
    MBAPM_PAGE = 5'h02,
    MBAPM_XA8 = 5'h04,
    MBAPM_ERW = 5'h08,
    MBAPM_NONMUX = 5'h10
  } mbapm_bus_e;

  localparam int MBAPM_PORTS = 4;
  localparam int MBAPM_PW = 8;
  localparam int MBAPM_PD_W = 3;
  localparam int MBAPM_PORT_D = 3;

  // io_register_space page: address bits 15..8
  localparam logic [7:0] MBAPM_IO_PAGE = 8'hB0;
  // low byte layout: bits 7..4 zero, 3..2 register kind, 1..0 port
  localparam int MBAPM_KIND_LSB = 2;
  localparam logic [1:0] MBAPM_KIND_DIN = 2'h0;
  localparam logic [1:0] MBAPM_KIND_CTL = 2'h1;
  localparam logic [1:0] MBAPM_KIND_DOUT = 2'h2;
  localparam logic [1:0] MBAPM_KIND_DIR = 2'h3;

  localparam logic [7:0] MBAPM_RST_CFG = 8'h00;
  localparam logic [7:0] MBAPM_ALL_OFF = 8'hFF;

  // per-port capability, bit n is port n (A=0)
  localparam logic [3:0] MBAPM_CTL_PORTS = 4'h3;
  localparam logic [3:0] MBAPM_PLD_OUT_PORTS = 4'hB;
  localparam logic [3:0] MBAPM_ADDR_OUT_PORTS = 4'h3;
  localparam logic [3:0] MBAPM_DATA_PORTS = 4'h1;
  localparam logic [3:0] MBAPM_JTAG_PORTS = 4'h4;

  function automatic int mbapm_width(input int idx);
    return (idx == MBAPM_PORT_D) ? MBAPM_PD_W : MBAPM_PW;
  endfunction

  function automatic logic [7:0] mbapm_wmask(input logic [1:0] idx);
    return (idx == 2'(MBAPM_PORT_D)) ? 8'h07 : 8'hFF;
  endfunction

endpackage

// ---- rtl/mbapm_port_if.sv ----
// Purpose: carries one port's controls from the core to its pin logic
// Assumes: eight lanes per port, unused upper lanes of port D ignored
// Notes: masks arrive already gated by port capability
`timescale 1ns/10ps
interface mbapm_port_if;
  logic [7:0] dout;
  logic [7:0] dir;
  logic [7:0] ctl;
  logic [7:0] addr;
  logic [7:0] gl;
  logic [7:0] pld_out;
  logic [7:0] block;
  logic [7:0] dp_data;
  logic dp_en;
  logic dp_drive;
  logic [7:0] pin_s;

  modport core (
    output dout, dir, ctl, addr, gl, pld_out, block, dp_data, dp_en,
    output dp_drive,
    input pin_s
  );
  modport pin (
    input dout, dir, ctl, addr, gl, pld_out, block, dp_data, dp_en,
    input dp_drive,
    output pin_s
  );
endinterface

// ---- rtl/mbapm_port.sv ----
// Purpose: one port: output mux, drive enable, pin input synchroniser
// Assumes: IDX selects port width; pins come from outside, so synced
// Notes: data port beats gl output beats host/address driving
`timescale 1ns/10ps
module mbapm_port #(
  parameter int IDX = 0
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  mbapm_port_if.pin pif,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_n_out
);
  localparam int W = mbapm_pkg::mbapm_width(IDX);

  logic [7:0] meta_reg;
  logic [7:0] sync_reg;
  logic [7:0] out_next;
  logic [7:0] oe_n_next;

  assign pif.pin_s = sync_reg;

  always_comb begin
    out_next = 8'h00;
    oe_n_next = mbapm_pkg::MBAPM_ALL_OFF;
    for (int i = 0; i < 8; i++) begin
      // reserved pins never drive, whatever the registers say
      if (i < W && !pif.block[i]) begin
        if (pif.dp_en) begin
          out_next[i] = pif.dp_data[i];
          oe_n_next[i] = ~pif.dp_drive;
        end else if (pif.pld_out[i]) begin
          out_next[i] = pif.gl[i];
          oe_n_next[i] = 1'b0;
        end else if (pif.dir[i]) begin
          out_next[i] = pif.ctl[i] ? pif.addr[i] : pif.dout[i];
          oe_n_next[i] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_in) begin
    meta_reg <= pin_in;
    sync_reg <= meta_reg;
    if (sys_rst_in) begin
      pin_out <= 8'h00;
      pin_oe_n_out <= mbapm_pkg::MBAPM_ALL_OFF;
    end else begin
      pin_out <= out_next;
      pin_oe_n_out <= oe_n_next;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_release_quiet: assert property (
    $past(sys_rst_in) |-> pin_oe_n_out == mbapm_pkg::MBAPM_ALL_OFF)
    else $error("pin driven right after reset");
  a_block_holds: assert property (
    !$past(sys_rst_in) |-> (($past(pif.block) & ~pin_oe_n_out) == 8'h00))
    else $error("reserved pin is driven");
  a_addr_follows: assert property (
    (!pif.dp_en && !pif.block[0] && !pif.pld_out[0] && pif.dir[0]
     && pif.ctl[0]) |=> (pin_out[0] == $past(pif.addr[0])
     && !pin_oe_n_out[0]))
    else $error("address out bit not driven from latched address");
  a_input_quiet: assert property (
    (!pif.dp_en && !pif.pld_out[1] && !pif.dir[1]) |=> pin_oe_n_out[1])
    else $error("input pin is driven");
endmodule // mbapm_port

// ---- rtl/mbapm_top.sv ----
// Purpose: host bus address capture, io registers and four port muxes
// Assumes: host strobes and pins are asynchronous to clk_in
// Notes: mode straps are captured while reset is high, then frozen
// Contract
// - Latch multiplexed low address byte on latch strobe, then serve strobes.
// - Non-page mode: low byte latched on every latch strobe pulse.
// - Page mode: high byte latched and reused; low byte taken live.
// - Eight-bit xa mode: bits 11..4 latched, bits 3..0 taken live.
// - Burst fetch: latched bits held while low nibble steps.
// - Enable plus read/write select accepted; separate strobes driven out.
// - Ports A, B, C of eight pins, D of three, each pin configurable.
// - A pin given one function is withheld from all others.
// - Output mux picks data-out, latched address or logic output.
// - Readback picks exactly one of data-out, direction, control, pin.
// - Logic i/o, data port and address-in fixed; others run-time.
// - Modes limited per port: address out A,B; data A; jtag C.
// - Control bit 0 host i/o, 1 address out; only ports A, B.
// - Direction bit 1 output, 0 input; port D uses three bits.
// - Control and direction registers come up zero.
// - Shared bus driven only when io page addressed and read active.
`timescale 1ns/10ps
module mbapm_top (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic write_strobe_input_in,
  input wire logic read_strobe_input_in,
  input wire logic fetch_strobe_input_in,
  input wire logic [7:0] adio_in,
  output logic [7:0] adio_out,
  output logic adio_oe_n_out,
  input wire logic [7:0] addr_direct_in,
  input wire mbapm_pkg::mbapm_bus_e cfg_bus_mode_in,
  input wire logic cfg_fetch_reads_in,
  input wire logic cfg_b_addr_hi_in,
  input wire logic cfg_jtag_in,
  input wire logic [3:0][7:0] cfg_pld_out_in,
  input wire logic [3:0][7:0] cfg_block_in,
  input wire logic [3:0][7:0] gl_in,
  input wire logic [3:0][7:0] pin_in,
  output logic [3:0][7:0] pin_out,
  output logic [3:0][7:0] pin_oe_n_out,
  output logic [15:0] addr_out,
  output logic rd_strobe_out,
  output logic wr_strobe_out
);
  // frozen configuration
  mbapm_pkg::mbapm_bus_e mode_reg, mode_next;
  logic fetch_reg, fetch_next;
  logic b_hi_reg, b_hi_next;
  logic jtag_reg, jtag_next;
  logic [3:0][7:0] pld_reg, pld_next;
  logic [3:0][7:0] blk_reg, blk_next;

  // synchronisers: first stage read only by second stage
  logic [2:0] smeta_reg;
  logic [2:0] ssync_reg;
  logic [7:0] ameta_reg;
  logic [7:0] async_reg;
  logic [7:0] dmeta_reg;
  logic [7:0] dsync_reg;

  // bus state
  logic [7:0] lat_reg, lat_next;
  logic wr_prev_reg, wr_prev_next;
  logic [3:0][7:0] dout_reg, dout_next;
  logic [3:0][7:0] dir_reg, dir_next;
  logic [3:0][7:0] ctl_reg, ctl_next;
  logic [7:0] adio_next;
  logic adio_oe_n_next;
  logic [15:0] addr_next;
  logic rd_next;
  logic wr_next;

  logic [3:0][7:0] pin_s;
  logic ale;
  logic nonmux;
  logic rd;
  logic wr;
  logic sel;
  logic [1:0] kind;
  logic [1:0] pidx;
  logic [15:0] eff;
  logic [7:0] wdata;
  logic [7:0] rdata;

  mbapm_port_if pif [4] ();

  // pins withheld from host use by the chosen bus wiring
  function automatic logic [7:0] bus_resv(input int p,
      input mbapm_pkg::mbapm_bus_e m, input logic jt);
    logic [7:0] r;
    r = 8'h00;
    if (p == 0 && m == mbapm_pkg::MBAPM_XA8) r = 8'h0F;
    if (p == mbapm_pkg::MBAPM_PORT_D && m != mbapm_pkg::MBAPM_NONMUX) begin
      r = 8'h01;
    end
    if (mbapm_pkg::MBAPM_JTAG_PORTS[p] && jt) r = 8'hFF;
    return r;
  endfunction

  always_comb begin
    mode_next = mode_reg;
    fetch_next = fetch_reg;
    b_hi_next = b_hi_reg;
    jtag_next = jtag_reg;
    pld_next = pld_reg;
    blk_next = blk_reg;
    // straps only load while reset is high
    if (sys_rst_in) begin
      mode_next = cfg_bus_mode_in;
      fetch_next = cfg_fetch_reads_in;
      b_hi_next = cfg_b_addr_hi_in;
      jtag_next = cfg_jtag_in;
      pld_next = cfg_pld_out_in;
      blk_next = cfg_block_in;
    end
  end

  always_ff @(posedge clk_in) begin
    mode_reg <= mode_next;
    fetch_reg <= fetch_next;
    b_hi_reg <= b_hi_next;
    jtag_reg <= jtag_next;
    pld_reg <= pld_next;
    blk_reg <= blk_next;
    smeta_reg <= {fetch_strobe_input_in, read_strobe_input_in,
                  write_strobe_input_in};
    ssync_reg <= smeta_reg;
    ameta_reg <= adio_in;
    async_reg <= ameta_reg;
    dmeta_reg <= addr_direct_in;
    dsync_reg <= dmeta_reg;
  end

  assign nonmux = (mode_reg == mbapm_pkg::MBAPM_NONMUX);
  assign ale = pin_s[mbapm_pkg::MBAPM_PORT_D][0];

  always_comb begin
    // effective address seen by decode and by address-out pins
    case (mode_reg)
      mbapm_pkg::MBAPM_PAGE: eff = {lat_reg, dsync_reg};
      mbapm_pkg::MBAPM_XA8: eff = {dsync_reg[7:4], lat_reg,
                                   pin_s[0][3:0]};
      mbapm_pkg::MBAPM_NONMUX: eff = {dsync_reg, async_reg};
      default: eff = {dsync_reg, lat_reg};
    endcase
    if (mode_reg == mbapm_pkg::MBAPM_ERW) begin
      // read input is the enable, write input high means read
      rd = ssync_reg[1] & ssync_reg[0];
      wr = ssync_reg[1] & ~ssync_reg[0];
    end else begin
      rd = ~ssync_reg[1] | (fetch_reg & ~ssync_reg[2]);
      wr = ~ssync_reg[0];
    end
    kind = eff[mbapm_pkg::MBAPM_KIND_LSB +: 2];
    pidx = eff[1:0];
    sel = (eff[15:8] == mbapm_pkg::MBAPM_IO_PAGE) && (eff[7:4] == 4'h0);
    wdata = nonmux ? pin_s[0] : async_reg;
    case (kind)
      mbapm_pkg::MBAPM_KIND_DIN: rdata = pin_s[pidx];
      mbapm_pkg::MBAPM_KIND_CTL: rdata = ctl_reg[pidx];
      mbapm_pkg::MBAPM_KIND_DOUT: rdata = dout_reg[pidx];
      mbapm_pkg::MBAPM_KIND_DIR: rdata = dir_reg[pidx];
      default: rdata = 8'h00;
    endcase
    rdata = rdata & mbapm_pkg::mbapm_wmask(pidx);
  end

  always_comb begin
    lat_next = lat_reg;
    wr_prev_next = wr;
    dout_next = dout_reg;
    dir_next = dir_reg;
    ctl_next = ctl_reg;
    // latch tracks the bus while strobe high, holds from its fall
    if (ale && !nonmux) begin
      lat_next = async_reg;
    end
    // commit a host write at the trailing edge of its strobe
    if (wr_prev_reg && !wr && sel) begin
      case (kind)
        mbapm_pkg::MBAPM_KIND_DOUT: dout_next[pidx] = wdata;
        mbapm_pkg::MBAPM_KIND_DIR:
          dir_next[pidx] = wdata & mbapm_pkg::mbapm_wmask(pidx);
        mbapm_pkg::MBAPM_KIND_CTL:
          if (mbapm_pkg::MBAPM_CTL_PORTS[pidx]) begin
            ctl_next[pidx] = wdata;
          end
        default: ;
      endcase
    end
    adio_next = rdata;
    adio_oe_n_next = ~(rd && sel && !nonmux);
    addr_next = eff;
    rd_next = rd;
    wr_next = wr;
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lat_reg <= 8'h00;
      wr_prev_reg <= 1'b0;
      dout_reg <= '0;
      dir_reg <= {4{mbapm_pkg::MBAPM_RST_CFG}};
      ctl_reg <= {4{mbapm_pkg::MBAPM_RST_CFG}};
      adio_out <= 8'h00;
      adio_oe_n_out <= 1'b1;
      addr_out <= 16'h0000;
      rd_strobe_out <= 1'b0;
      wr_strobe_out <= 1'b0;
    end else begin
      lat_reg <= lat_next;
      wr_prev_reg <= wr_prev_next;
      dout_reg <= dout_next;
      dir_reg <= dir_next;
      ctl_reg <= ctl_next;
      adio_out <= adio_next;
      adio_oe_n_out <= adio_oe_n_next;
      addr_out <= addr_next;
      rd_strobe_out <= rd_next;
      wr_strobe_out <= wr_next;
    end
  end

  for (genvar p = 0; p < mbapm_pkg::MBAPM_PORTS; p++) begin : g_port
    logic [7:0] resv;
    assign resv = bus_resv(p, mode_reg, jtag_reg) | blk_reg[p];
    assign pif[p].dout = dout_reg[p];
    assign pif[p].dir = dir_reg[p];
    // address out only where the port supports it
    assign pif[p].ctl = mbapm_pkg::MBAPM_ADDR_OUT_PORTS[p] ?
                        ctl_reg[p] : 8'h00;
    assign pif[p].addr = (p == 1 && b_hi_reg) ? eff[15:8] : eff[7:0];
    assign pif[p].gl = gl_in[p];
    assign pif[p].pld_out = mbapm_pkg::MBAPM_PLD_OUT_PORTS[p] ?
                            (pld_reg[p] & ~resv) : 8'h00;
    assign pif[p].block = resv;
    assign pif[p].dp_data = rdata;
    assign pif[p].dp_en = mbapm_pkg::MBAPM_DATA_PORTS[p] && nonmux;
    assign pif[p].dp_drive = rd && sel && nonmux;
    assign pin_s[p] = pif[p].pin_s;
    mbapm_port #(.IDX(p)) u_port (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pif(pif[p]),
      .pin_in(pin_in[p]),
      .pin_out(pin_out[p]),
      .pin_oe_n_out(pin_oe_n_out[p])
    );
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  a_bus_drive: assert property (
    !adio_oe_n_out |-> $past(rd && sel && !nonmux))
    else $error("shared bus driven outside an io read");
  a_cfg_frozen: assert property (
    !$past(sys_rst_in) |-> $stable(mode_reg) && $stable(pld_reg))
    else $error("fixed configuration changed at run time");
  a_reset_zero: assert property (
    $past(sys_rst_in) |-> dir_reg == '0 && ctl_reg == '0)
    else $error("config registers not zero after reset");
  a_ctl_cd_zero: assert property (
    ctl_reg[2] == 8'h00 && ctl_reg[3] == 8'h00)
    else $error("control bits set on port without control register");
  a_dir_d_width: assert property (
    dir_reg[mbapm_pkg::MBAPM_PORT_D][7:3] == 5'h00)
    else $error("port D direction upper bits set");
  a_latch_hold: assert property (
    !ale ##1 !ale |-> $stable(lat_reg))
    else $error("latched address moved without latch strobe");
  a_latch_take: assert property (
    (ale && !nonmux) |=> lat_reg == $past(async_reg))
    else $error("latch strobe did not capture bus");
  a_dout_write: assert property (
    (wr_prev_reg && !wr && sel && kind == mbapm_pkg::MBAPM_KIND_DOUT)
    |=> dout_reg[$past(pidx)] == $past(wdata))
    else $error("data out write lost");
endmodule // mbapm_top

// ---- dv/mbapm_host_model.sv ----
// Purpose: host microcontroller model on an 8-bit multiplexed bus
// Assumes: device strapped for the multiplexed mode, io page on direct
// Notes: released data lines show the inverse of the last value driven
`timescale 1ns/10ps
module mbapm_host_model (
  input wire logic clk_in,
  input wire logic [7:0] adio_in,
  input wire logic adio_oe_n_in,
  output logic wr_n_out,
  output logic rd_n_out,
  output logic fetch_n_out,
  output logic ale_out,
  output logic [7:0] adio_out,
  output logic [7:0] direct_out
);
  initial begin
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
    fetch_n_out = 1'b1;
    ale_out = 1'b0;
    adio_out = 8'h00;
    direct_out = 8'h00;
  end

  // bus_write and bus_read open with a latch pulse; hit_read issues page hits without one
  task automatic addr_phase(input logic [15:0] a);
    @(posedge clk_in);
    direct_out <= a[15:8];
    adio_out <= a[7:0];
    ale_out <= 1'b1;
    repeat (3) @(posedge clk_in);
    ale_out <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    addr_phase(a);
    adio_out <= d;
    wr_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr_n_out <= 1'b1;
    @(posedge clk_in);
    adio_out <= ~d;
    repeat (8) @(posedge clk_in);
  endtask

  // strobe and wait for the answer; address already on the lines
  task automatic strobe_read(input logic fetch, output logic [7:0] d,
                             output logic drv);
    d = 8'h00;
    drv = 1'b0;
    if (fetch) begin
      fetch_n_out <= 1'b0;
    end else begin
      rd_n_out <= 1'b0;
    end
    // bounded wait: an unselected device never answers
    for (int i = 0; i < 12 && !drv; i++) begin
      @(posedge clk_in);
      if (adio_oe_n_in === 1'b0) begin
        d = adio_in;
        drv = 1'b1;
      end
    end
    @(posedge clk_in);
    rd_n_out <= 1'b1;
    fetch_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask

  task automatic bus_read(input logic [15:0] a, input logic fetch,
                          output logic [7:0] d, output logic drv);
    addr_phase(a);
    adio_out <= ~a[7:0];
    strobe_read(fetch, d, drv);
  endtask

  // page hit or burst step: no latch pulse, only live lines move
  task automatic hit_read(input logic [7:0] lo, output logic [7:0] d,
                          output logic drv);
    @(posedge clk_in);
    direct_out <= lo;
    strobe_read(1'b0, d, drv);
  endtask
endmodule // mbapm_host_model

// ---- dv/tb.sv ----
// Purpose: self-checking bench for address capture and port muxes
// Assumes: io page high byte 0xB0; bus mode strap moves only with reset
// Notes: straps are set before each reset and held until the next one
`timescale 1ns/10ps
module tb;
  logic clk_in, sys_rst_in, wr_n, rd_n, fetch_n, ale, adio_oe_n, drv;
  logic rd_s, wr_s, fetch_cfg, erw, e_pin;
  logic [1:0] strobe_seen;
  logic [7:0] porta_seen;
  mbapm_pkg::mbapm_bus_e mode;
  logic [7:0] adio_h, adio_d, direct, rdata;
  logic [15:0] addr_out;
  logic [3:0][7:0] pins, pin_w, gl, pld, blk, pin_out, pin_oe_n;
  int mismatches, n_compared;

  always_comb begin
    pin_w = pins;
    pin_w[3][0] = ale;
  end

  // enable-style host: enable high during either strobe, select is write
  always_comb e_pin = erw ? ~(rd_n & wr_n) : rd_n;

  // sticky record of decoded strobes and of port A drive
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      strobe_seen <= 2'b00;
      porta_seen <= 8'h00;
    end else begin
      strobe_seen <= strobe_seen | {rd_s, wr_s};
      if (pin_oe_n[0] == 8'h00) begin
        porta_seen <= pin_out[0];
      end
    end
  end

  mbapm_host_model mbapm_host_model_inst (.clk_in(clk_in),
    .adio_in(adio_d), .adio_oe_n_in(adio_oe_n), .wr_n_out(wr_n),
    .rd_n_out(rd_n), .fetch_n_out(fetch_n), .ale_out(ale),
    .adio_out(adio_h), .direct_out(direct));

  mbapm_top mbapm_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .write_strobe_input_in(wr_n), .read_strobe_input_in(e_pin),
    .fetch_strobe_input_in(fetch_n), .adio_in(adio_h),
    .adio_out(adio_d), .adio_oe_n_out(adio_oe_n),
    .addr_direct_in(direct), .cfg_bus_mode_in(mode),
    .cfg_fetch_reads_in(fetch_cfg), .cfg_b_addr_hi_in(1'b0),
    .cfg_jtag_in(1'b0), .cfg_pld_out_in(pld), .cfg_block_in(blk),
    .gl_in(gl), .pin_in(pin_w), .pin_out(pin_out),
    .pin_oe_n_out(pin_oe_n), .addr_out(addr_out),
    .rd_strobe_out(rd_s), .wr_strobe_out(wr_s));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    mbapm_host_model_inst.bus_write({8'hB0, a}, d);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [7:0] exp);
    mbapm_host_model_inst.bus_read({8'hB0, a}, 1'b0, rdata, drv);
    check(what, {7'h00, drv, rdata}, {8'h01, exp});
  endtask

  task automatic do_reset();
    @(posedge clk_in);
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    check("oe in reset", {pin_oe_n[1], pin_oe_n[0]}, 16'hFFFF);
    @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    #1;
    check("idle", {13'h0000, rd_s, wr_s, adio_oe_n}, 16'h0001);
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // whole sequence needs roughly 650 cycles
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    final_report();
  end

  initial begin
    sys_rst_in = 1'b1;
    fetch_cfg = 1'b1;
    mode = mbapm_pkg::MBAPM_MUX8;
    erw = 1'b0;
    pins = '0;
    gl = '0;
    pld = '0;
    blk = '0;
    pld[1] = 8'h01;
    blk[1] = 8'h80;
    mismatches = 0;
    n_compared = 0;
    do_reset();
    rd_chk("ctl a", 8'h04, 8'h00);
    rd_chk("dir a", 8'h0C, 8'h00);
    rd_chk("dout a", 8'h08, 8'h00);
    wr(8'h08, 8'h5A);
    wr(8'h0C, 8'hFF);
    #1;
    check("pin a", {pin_oe_n[0], pin_out[0]}, 16'h005A);
    rd_chk("dout a", 8'h08, 8'h5A);
    rd_chk("dir a", 8'h0C, 8'hFF);
    wr(8'h04, 8'h0F);
    #1;
    check("addr out a", {8'h00, pin_out[0]}, 16'h0054);
    rd_chk("ctl a", 8'h04, 8'h0F);
    rd_chk("dir a", 8'h0C, 8'hFF);
    #1;
    check("addr out a", {8'h00, pin_out[0]}, 16'h005C);
    check("addr", addr_out, 16'hB00C);
    mbapm_host_model_inst.bus_read(16'hB008, 1'b1, rdata, drv);
    check("fetch read", {7'h00, drv, rdata}, 16'h015A);
    check("strobes", {14'h0000, strobe_seen}, 16'h0003);
    wr(8'h0F, 8'hFF);
    rd_chk("dir d", 8'h0F, 8'h07);
    #1;
    check("oe d", {8'h00, pin_oe_n[3]}, 16'h00F9);
    wr(8'h06, 8'hFF);
    rd_chk("ctl c", 8'h06, 8'h00);
    @(posedge clk_in);
    pins[2] <= 8'hA5;
    rd_chk("pin c", 8'h02, 8'hA5);
    mbapm_host_model_inst.bus_read(16'hB050, 1'b0, rdata, drv);
    check("unmapped low", {15'h0000, drv}, 16'h0000);
    mbapm_host_model_inst.bus_read(16'hC00C, 1'b0, rdata, drv);
    check("unmapped page", {15'h0000, drv}, 16'h0000);
    @(posedge clk_in);
    gl[1] <= 8'h01;
    wr(8'h0D, 8'hFF);
    wr(8'h09, 8'h00);
    #1;
    check("oe b", {8'h00, pin_oe_n[1]}, 16'h0080);
    check("pin b", {9'h000, pin_out[1][6:0]}, 16'h0001);
    @(posedge clk_in);
    gl[1] <= 8'h00;
    repeat (3) @(posedge clk_in);
    #1;
    check("pin b", {9'h000, pin_out[1][6:0]}, 16'h0000);
    do_reset();
    rd_chk("dir a", 8'h0C, 8'h00);
    // page mode: high byte rides the shared lines, low byte direct
    @(posedge clk_in);
    mode <= mbapm_pkg::MBAPM_PAGE;
    do_reset();
    mbapm_host_model_inst.bus_write(16'h09B0, 8'hC3);
    mbapm_host_model_inst.bus_write(16'h0DB0, 8'h7E);
    mbapm_host_model_inst.bus_read(16'h09B0, 1'b0, rdata, drv);
    check("page dout b", {7'h00, drv, rdata}, 16'h01C3);
    mbapm_host_model_inst.hit_read(8'h0D, rdata, drv);
    check("page hit dir b", {7'h00, drv, rdata}, 16'h017E);
    #1;
    check("page addr", addr_out, 16'hB00D);
    // eight-bit xa: low nibble live on port A, burst steps it alone
    @(posedge clk_in);
    mode <= mbapm_pkg::MBAPM_XA8;
    pins[0] <= 8'h08;
    do_reset();
    wr(8'h00, 8'h3C);
    @(posedge clk_in);
    pins[0] <= 8'h0C;
    wr(8'h00, 8'hF0);
    @(posedge clk_in);
    pins[0] <= 8'h08;
    mbapm_host_model_inst.bus_read(16'hB000, 1'b0, rdata, drv);
    check("xa dout a", {7'h00, drv, rdata}, 16'h013C);
    @(posedge clk_in);
    pins[0] <= 8'h0C;
    mbapm_host_model_inst.hit_read(8'hB0, rdata, drv);
    check("burst dir a", {7'h00, drv, rdata}, 16'h01F0);
    #1;
    check("xa pins a", {pin_oe_n[0], pin_out[0]}, 16'h0F30);
    // plain bus: address on the shared lines, data through port A
    @(posedge clk_in);
    mode <= mbapm_pkg::MBAPM_NONMUX;
    pins[0] <= 8'h5C;
    do_reset();
    mbapm_host_model_inst.addr_phase(16'hB000);
    mbapm_host_model_inst.strobe_read(1'b0, rdata, drv);
    check("shared bus quiet", {15'h0000, drv}, 16'h0000);
    check("data port", {8'h00, porta_seen}, 16'h005C);
    #1;
    check("data port idle", {8'h00, pin_oe_n[0]}, 16'h00FF);
    // enable plus read/write select host
    @(posedge clk_in);
    mode <= mbapm_pkg::MBAPM_ERW;
    erw <= 1'b1;
    do_reset();
    wr(8'h08, 8'h96);
    rd_chk("erw dout a", 8'h08, 8'h96);
    check("erw strobes", {14'h0000, strobe_seen}, 16'h0003);
    final_report();
  end
endmodule // tb
